// [rtl/sgd_consts.vh]
`ifndef SGD_CONSTS_VH
`define SGD_CONSTS_VH
// ----------------------------------------
// register offsets (byte addresses)
// ----------------------------------------
`define SGD_OFF_CTRL_A 8'hc8
`define SGD_OFF_CTRL_B 8'hcc
`define SGD_OFF_CTRL_C 8'hd0
// ----------------------------------------
// reset values
// ----------------------------------------
`define SGD_RST_CTRL_A 32'h0000_0001
`define SGD_RST_CTRL_B 32'h0000_0000
`define SGD_RST_CTRL_C 32'h3214_0000
`define SGD_RST_PIN_DATA 5'h00
`define SGD_RST_PIN_BIT 1'b0
// ----------------------------------------
// pin data field layout
// ----------------------------------------
`define SGD_PIN_W 5
`define SGD_ZERO_HI 27'h0000000
`endif

// [rtl/sgd_pin_bit.v]
`include "sgd_consts.vh"
// ----------------------------------------
// one general-purpose pin data bit
// ----------------------------------------
module sgd_pin_bit
(
    input wire i_sys_clk,
    input wire i_fundamental_reset_n_n_sync,
    input wire i_valid,
    input wire i_dir_out,
    input wire i_pin_sync,
    input wire i_wr,
    input wire i_wdata,
    input wire i_ee_load,
    input wire i_ee_data,
    output wire o_read,
    output reg o_drive_q
);
    // value shown on read: pin level in input mode, latch in output mode
    assign o_read = i_dir_out ? o_drive_q : i_pin_sync;

    // data latch: fundamental reset, then eeprom preload, then software write
    always @(posedge i_sys_clk)
    begin
        // R6 - reset then preload
        if (!i_fundamental_reset_n_n_sync)
        begin
            o_drive_q <= `SGD_RST_PIN_BIT;
        end
        else if (i_ee_load && i_valid)
        begin
            o_drive_q <= i_ee_data;
        end
        // R1 - input mode ignores writes
        else if (i_wr && i_valid && i_dir_out)
        begin
            o_drive_q <= i_wdata;
        end
    end
endmodule

// [rtl/sgd_regs.v]
// Notes on behaviour
// R1 - input pin: read level, ignore writes
// R2 - output pin: write drives, read returns it
// R3 - bits 2:0 writable only if first strap low
// R4 - bit 4 writable only if second strap low
// R5 - bit 3 always valid, no strap
// R6 - valid bits preload from eeprom, fundamental reset clears
// R7 - bits 0 and 4 hot-plug outputs
// R8 - bits 1 and 2 hot-plug inputs
// R9 - C8h reserved register resets to 0001h
// R10 - eeprom image for C8h holds 00000001h
// R11 - CCh reserved register resets to zero
// R12 - D0h reserved register resets to 32140000h
// R13 - software leaves reserved registers at default
// R14 - pcie reset restores reserved registers
// R15 - pin direction comes from outside block
`include "sgd_consts.vh"
module sgd_regs
(
    input wire i_sys_clk,
    input wire i_rstn,
    input wire i_fundamental_reset_n,
    input wire i_first_downport_strap,
    input wire i_second_downport_strap,
    input wire [4:0] i_pin_dir_out,
    input wire [4:0] i_pin_level,
    input wire i_cfg_wr,
    input wire i_cfg_rd,
    input wire [7:0] i_cfg_addr,
    input wire [31:0] i_cfg_wdata,
    input wire i_ee_load,
    input wire [7:0] i_ee_addr,
    input wire [31:0] i_ee_data,
    input wire i_pin_data_sel,
    output reg [31:0] o_cfg_rdata,
    output reg [4:0] o_pin_out,
    output reg [4:0] o_pin_oe
);
    // ----------------------------------------
    // synchronisers for pins, straps and fundamental reset
    // ----------------------------------------
    reg [7:0] sync1_q;
    reg [7:0] sync2_q;
    wire [7:0] async_in;
    assign async_in = {i_fundamental_reset_n, i_second_downport_strap,
                       i_first_downport_strap, i_pin_level};

    // two flops before any logic; straps and the reset pin are slow levels,
    // so a plain chain is enough to keep metastability off the latches
    always @(posedge i_sys_clk)
    begin
        sync1_q <= async_in;
        sync2_q <= sync1_q;
    end

    wire [4:0] pin_sync;
    wire strap1_sync;
    wire strap2_sync;
    wire fundamental_reset_n_n_sync;
    // R8 - input pins read synced level
    assign pin_sync = sync2_q[4:0];
    assign strap1_sync = sync2_q[5];
    assign strap2_sync = sync2_q[6];
    assign fundamental_reset_n_n_sync = sync2_q[7];

    // ----------------------------------------
    // per-bit validity from straps
    // ----------------------------------------
    // a set strap turns the bit read-only; it still reads level or latch
    wire [4:0] bit_valid;
    // R3 - first strap gates 2:0
    assign bit_valid[2:0] = {3{~strap1_sync}};
    // R5 - bit 3 always valid
    assign bit_valid[3] = 1'b1;
    // R4 - second strap gates 4
    assign bit_valid[4] = ~strap2_sync;

    // hot-plug roles of the pins (R7, R8 only describe use)
    // writes and preloads reach the latches only with the pin select high
    wire pin_wr;
    assign pin_wr = i_cfg_wr && i_pin_data_sel;

    // ----------------------------------------
    // pin data bits
    // ----------------------------------------
    wire [4:0] pin_read;
    wire [4:0] pin_drive;
    genvar gi;
    generate
        for (gi = 0; gi < `SGD_PIN_W; gi = gi + 1)
        begin : g_pin
            // R2 - output latch per pin
            sgd_pin_bit u_bit
            (
                .i_sys_clk(i_sys_clk),
                .i_fundamental_reset_n_n_sync(fundamental_reset_n_n_sync),
                .i_valid(bit_valid[gi]),
                .i_dir_out(i_pin_dir_out[gi]),
                .i_pin_sync(pin_sync[gi]),
                .i_wr(pin_wr),
                .i_wdata(i_cfg_wdata[gi]),
                .i_ee_load(i_ee_load && i_pin_data_sel),
                .i_ee_data(i_ee_data[gi]),
                .o_read(pin_read[gi]),
                .o_drive_q(pin_drive[gi])
            );
        end
    endgenerate

    // ----------------------------------------
    // pin outputs from flops
    // ----------------------------------------
    // R15 - direction from outside
    always @(posedge i_sys_clk)
    begin
        if (!i_rstn)
        begin
            o_pin_out <= `SGD_RST_PIN_DATA;
            o_pin_oe <= `SGD_RST_PIN_DATA;
        end
        else
        begin
            // R7 - outputs drive pin
            o_pin_out <= pin_drive;
            // enable follows direction one cycle late, in step with the data
            o_pin_oe <= i_pin_dir_out;
        end
    end

    // ----------------------------------------
    // reserved vendor registers
    // ----------------------------------------
    reg [31:0] ctrl_a_q;
    reg [31:0] ctrl_b_q;
    reg [31:0] ctrl_c_q;
    wire wr_a;
    wire wr_b;
    wire wr_c;
    // eeprom load takes the same path as a config write and wins over one
    // in the same cycle, so a stray write cannot spoil the preloaded word
    wire cfg_vend_wr;
    wire ee_vend_wr;
    assign cfg_vend_wr = i_cfg_wr && !i_ee_load && !i_pin_data_sel;
    assign ee_vend_wr = i_ee_load && !i_pin_data_sel;
    assign wr_a = (cfg_vend_wr && i_cfg_addr == `SGD_OFF_CTRL_A)
                  || (ee_vend_wr && i_ee_addr == `SGD_OFF_CTRL_A);
    assign wr_b = (cfg_vend_wr && i_cfg_addr == `SGD_OFF_CTRL_B)
                  || (ee_vend_wr && i_ee_addr == `SGD_OFF_CTRL_B);
    assign wr_c = (cfg_vend_wr && i_cfg_addr == `SGD_OFF_CTRL_C)
                  || (ee_vend_wr && i_ee_addr == `SGD_OFF_CTRL_C);
    wire [31:0] wval;
    assign wval = i_ee_load ? i_ee_data : i_cfg_wdata;

    // storage; i_rstn is the pcie reset
    // writes are not blocked: software is trusted to leave the defaults alone
    always @(posedge i_sys_clk)
    begin
        // R14 - pcie reset restores defaults
        if (!i_rstn)
        begin
            // R9 - C8h default
            ctrl_a_q <= `SGD_RST_CTRL_A;
            // R11 - CCh default
            ctrl_b_q <= `SGD_RST_CTRL_B;
            // R12 - D0h default
            ctrl_c_q <= `SGD_RST_CTRL_C;
        end
        else
        begin
            if (wr_a)
            begin
                ctrl_a_q <= wval;
            end
            if (wr_b)
            begin
                ctrl_b_q <= wval;
            end
            if (wr_c)
            begin
                ctrl_c_q <= wval;
            end
        end
    end

    // ----------------------------------------
    // read data, registered
    // ----------------------------------------
    reg [31:0] rd_d;
    // read mux
    always @*
    begin
        rd_d = 32'h0000_0000;
        if (i_pin_data_sel)
        begin
            // pin data bits above 4 live elsewhere and read as zero here
            rd_d = {`SGD_ZERO_HI, pin_read};
        end
        else
        begin
            case (i_cfg_addr)
                `SGD_OFF_CTRL_A: rd_d = ctrl_a_q;
                `SGD_OFF_CTRL_B: rd_d = ctrl_b_q;
                `SGD_OFF_CTRL_C: rd_d = ctrl_c_q;
                default: rd_d = 32'h0000_0000;
            endcase
        end
    end

    // capture on read strobe
    // between reads the last word stays for software to pick up
    always @(posedge i_sys_clk)
    begin
        if (!i_rstn)
        begin
            o_cfg_rdata <= 32'h0000_0000;
        end
        else if (i_cfg_rd)
        begin
            o_cfg_rdata <= rd_d;
        end
    end
endmodule

// [testbench/sgd_pin_model.sv]
// ----
// pins and eeprom image
// ----
module sgd_pin_model
(
    input wire [4:0] i_oe,
    input wire [4:0] i_drv,
    input wire [4:0] i_ext,
    input wire [1:0] i_sel,
    output wire [4:0] o_level,
    output wire [7:0] o_ee_addr,
    output wire [31:0] o_ee_data
);
    timeunit 1ns;
    timeprecision 1ps;
    // device drive wins, else the outside source
    assign o_level = (i_oe & i_drv) | (~i_oe & i_ext);
    assign o_ee_addr = 8'hc8 + {4'h0, i_sel, 2'b00};
    // word 3 is an arbitrary pin data image
    assign o_ee_data = i_sel == 2'd0 ? 32'h0000_0001 : i_sel == 2'd2 ? 32'h3214_0000
        : i_sel == 2'd3 ? 32'h0000_0015 : 32'h0000_0000;
endmodule

// [testbench/sgd_regs_asserts.sv]
// ----
// port checker
// ----
module sgd_regs_asserts
(
    input wire i_sys_clk,
    input wire i_rstn,
    input wire [4:0] i_pin_dir_out,
    input wire [4:0] i_pin_level,
    input wire i_cfg_wr,
    input wire i_cfg_rd,
    input wire [7:0] i_cfg_addr,
    input wire [31:0] i_cfg_wdata,
    input wire i_ee_load,
    input wire [7:0] i_ee_addr,
    input wire [31:0] i_ee_data,
    input wire i_pin_data_sel,
    input wire [31:0] o_cfg_rdata,
    input wire [4:0] o_pin_oe
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (!i_rstn);
    // lone vendor read and mapped offset
    wire vrd = i_cfg_rd && !i_cfg_wr && !i_ee_load && !i_pin_data_sel;
    wire vmap = i_cfg_addr == 8'hc8 || i_cfg_addr == 8'hcc || i_cfg_addr == 8'hd0;
    a_write_read_back: assert property (
        i_cfg_wr && !i_ee_load && !i_pin_data_sel && vmap ##1 vrd && $stable(i_cfg_addr)
        |=> o_cfg_rdata == $past(i_cfg_wdata, 2)) else $error("vendor readback wrong");
    a_eeprom_preload: assert property (
        i_ee_load && !i_pin_data_sel && i_ee_addr == i_cfg_addr && vmap ##1 vrd
        && $stable(i_cfg_addr) |=> o_cfg_rdata == $past(i_ee_data, 2)) else $error("preload bad");
    a_perst_default: assert property (
        $rose(i_rstn) ##0 vrd |=> o_cfg_rdata == ($past(i_cfg_addr) == 8'hd0 ? 32'h3214_0000
        : {31'h0, $past(i_cfg_addr) == 8'hc8})) else $error("default after reset wrong");
    a_unmapped_zero: assert property (
        vrd && !vmap |=> o_cfg_rdata == 32'h0) else $error("unmapped read not zero");
    a_rdata_holds: assert property (
        !i_cfg_rd |=> $stable(o_cfg_rdata)) else $error("read data moved");
    a_oe_is_dir: assert property (
        $past(i_rstn) |-> o_pin_oe == $past(i_pin_dir_out)) else $error("enable not direction");
    a_pin_upper_zero: assert property (
        i_cfg_rd && i_pin_data_sel |=> o_cfg_rdata[31:5] == 27'h0) else $error("upper bits set");
    a_input_level: assert property (
        (i_pin_dir_out == 5'h00 && $stable(i_pin_level))[*3] ##0 i_cfg_rd && i_pin_data_sel
        |=> o_cfg_rdata[4:0] == $past(i_pin_level)) else $error("input read wrong");
endmodule
bind sgd_regs sgd_regs_asserts u_sgd_regs_asserts
(
    .i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_pin_dir_out(i_pin_dir_out),
    .i_pin_level(i_pin_level), .i_cfg_wr(i_cfg_wr), .i_cfg_rd(i_cfg_rd),
    .i_cfg_addr(i_cfg_addr), .i_cfg_wdata(i_cfg_wdata), .i_ee_load(i_ee_load),
    .i_ee_addr(i_ee_addr), .i_ee_data(i_ee_data), .i_pin_data_sel(i_pin_data_sel),
    .o_cfg_rdata(o_cfg_rdata), .o_pin_oe(o_pin_oe)
);

// [testbench/switch_gpio_data_and_reserved_regs_tb_top.sv]
module switch_gpio_data_and_reserved_regs_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, rstn = 0, fundamental_reset_n_n = 0, s1 = 0, s2 = 0, wr = 0, rd = 0, ee = 0, sel = 0;
    logic [4:0] dir = 0, ext = 0, pin, m;
    logic [7:0] addr = 0, a;
    logic [31:0] wdata = 0, d;
    logic [1:0] eesel = 0;
    wire [4:0] level, pout, poe;
    wire [7:0] eaddr;
    wire [31:0] edata, rdata;
    int errors = 0, checked = 0, v;
    int dflt[$] = '{1, 0, 'h32140000};
    always #2 clk = ~clk;
    sgd_regs u_sgd_regs (.i_sys_clk(clk), .i_rstn(rstn), .i_fundamental_reset_n(fundamental_reset_n_n),
        .i_first_downport_strap(s1), .i_second_downport_strap(s2), .i_pin_dir_out(dir),
        .i_pin_level(level), .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(addr),
        .i_cfg_wdata(wdata), .i_ee_load(ee), .i_ee_addr(eaddr), .i_ee_data(edata),
        .i_pin_data_sel(sel), .o_cfg_rdata(rdata), .o_pin_out(pout), .o_pin_oe(poe));
    sgd_pin_model u_sgd_pin_model (.i_oe(poe), .i_drv(pout), .i_ext(ext), .i_sel(eesel),
        .o_level(level), .o_ee_addr(eaddr), .o_ee_data(edata));
    // step cycles, landing just after the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            errors++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask
    // one request, strobes left for the caller
    task automatic acc(input logic s, input logic [7:0] ad, input logic [31:0] dt, input logic w);
        sel = s;
        addr = ad;
        wdata = dt;
        wr = w;
        rd = !w;
        cyc(1);
    endtask
    // reset, then read defaults from the first edge
    task automatic perst();
        rstn = 0;
        cyc(10);
        rstn = 1;
        for (int i = 0; i < 4; i++)
        begin
            acc(0, 8'hc8 + 8'(4 * i), 0, 0);
            chk("vendor_rst", i < 3 ? dflt[i] : 0, rdata);
        end
        rd = 0;
    endtask
    task automatic complete_run();
        if (errors == 0 && checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        void'($urandom(60212));
        perst();
        fundamental_reset_n_n = 1;
        // preload beats a write, then plain write
        for (int i = 0; i < 3; i++)
        begin
            eesel = 2'(i);
            a = 8'hc8 + 8'(4 * i);
            ee = 1;
            acc(0, a, $urandom, 1);
            ee = 0;
            acc(0, a, 0, 0);
            chk("vendor_ee", dflt[i], rdata);
            v = $urandom;
            acc(0, a, v, 1);
            acc(0, a, 0, 0);
            chk("vendor_wr", v, rdata);
        end
        // erroneous writes above are undone here
        perst();
        dir = 5'h1f;
        cyc(3);
        acc(1, 0, 0, 0);
        chk("pin_rst", 0, rdata);
        rd = 0;
        ee = 1;
        eesel = 3;
        // preload, strap cases, then input mode
        for (int k = 0; k < 6; k++)
        begin
            cyc(3);
            d = $urandom;
            acc(1, 0, d, 1);
            ee = 0;
            wr = 0;
            m = dir & {!s2, 1'b1, {3{!s1}}};
            pin = k == 0 ? 5'h15 : (pin & ~m) | (d[4:0] & m);
            cyc(3);
            chk("pin_out", pin & dir, pout & dir);
            acc(1, 0, 0, 0);
            rd = 0;
            chk("pin_rd", (pin & dir) | (ext & ~dir), rdata);
            {s2, s1, dir} = {2'(k), k < 4 ? 5'h1f : 5'h00};
            ext = 5'($urandom);
        end
        // back to output mode: the input-mode write must not have landed
        cyc(1);
        dir = 5'h1f;
        cyc(3);
        chk("pin_hold", pin, pout);
        acc(1, 0, 0, 0);
        rd = 0;
        chk("pin_keep", pin, rdata);
        // fundamental reset in mid-run clears the latches
        fundamental_reset_n_n = 0;
        cyc(4);
        fundamental_reset_n_n = 1;
        cyc(3);
        acc(1, 0, 0, 0);
        rd = 0;
        chk("pin_fundamental_reset_n", 0, rdata);
        complete_run();
    end
endmodule
